// ===== rtl/cms_clock_mode.sv
// clock mode select, reference comparison and output clock divide
// What this block does
// R1: software writes a two-bit mode request and reads the actual mode
// R2: actual mode follows request only when stability flags allow it
// R3: modes coded 00 self, 01 engaged int, 10 bypassed ext, 11 engaged ext
// R4: actual mode never changes in the cycle of the request write
// R5: first control write must pick crystal, else reference select locks 0
// R6: self and engaged-int compare over 8 internal reference periods
// R7: engaged-ext compares over 2 or 128 external periods by range
// R8: engaged-ext outputs divide by 2R until first lock or relock
// R9: self mode outputs oscillator over R, bypassed outputs external over R
// R10: engaged-int frequency is internal over 7 times 64 times N over R
// R11: engaged-ext frequency is external times P times N over R
// R12: multiply code decodes to N of 4 through 18 in steps of 2
// R13: divide code decodes to R of 1 through 128 in powers of 2
// R14: fixed clock is external over 2 when ratio at least 4 and settled
// R15: fixed clock stops in self and engaged-int modes
// R16: peripherals do not use fixed clock in self or engaged-int modes
// R17: high-gain oscillator chosen by its bit, only with external selected
// R18: high-gain bit takes only the first write after reset
// R19: external stable flag set when reference meets least frequency, and forced set in bypassed request without oscillator
// R20: multiply or mode request change clears settled until relock
// R21: settings pass two sync stages, output switches only at period wrap or while stopped, except a stop, which takes effect at once
// R22: software keeps output times R under the oscillator maximum
//
// Added by the designer: strobed register access and the placing of the registers.
`default_nettype none
module cms_clock_mode #(
   parameter int MON_WINDOW = 256,
   parameter int EXT_MIN_EDGES = 2,
   parameter int DCO_MIN_COUNT = 1,
   parameter int LOCK_TOL = 2,
   parameter int LOCK_SAMPLES = 4
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [1:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdData,
   input wire logic extRefClock,
   input wire logic digOscClock,
   input wire logic intRefClock,
   input wire logic busClockInternal,
   output logic clockGenOutput,
   output logic fixedFreqClock,
   output logic oscAmpEnable,
   output logic highGainOsc,
   output cms_pkg::cms_mode_t modeActual,
   output logic extRefStableFlag,
   output logic digOscStableFlag,
   output logic fllSettledFlag
);
   import cms_pkg::*;

   // pin synchronisers, three flops each
   logic [2:0] extSync_reg, dcoSync_reg, intSync_reg;
   logic extTick, dcoTick, intTick;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         extSync_reg <= 3'h0;
         dcoSync_reg <= 3'h0;
         intSync_reg <= 3'h0;
      end else begin
         extSync_reg <= {extSync_reg[1:0], extRefClock};
         dcoSync_reg <= {dcoSync_reg[1:0], digOscClock};
         intSync_reg <= {intSync_reg[1:0], intRefClock};
      end
   end

   // rising edge once second stage is high and third still low
   assign extTick = extSync_reg[1] & ~extSync_reg[2];
   assign dcoTick = dcoSync_reg[1] & ~dcoSync_reg[2];
   assign intTick = intSync_reg[1] & ~intSync_reg[2];

   // software-visible control state
   logic hgo_reg, hgo_next;
   logic range_reg, range_next;
   logic refSel_reg, refSel_next;
   logic [1:0] modeReq_reg, modeReq_next;
   logic [2:0] mult_reg, mult_next;
   logic [2:0] div_reg, div_next;
   logic firstWr_reg, firstWr_next;
   logic refLock_reg, refLock_next;
   logic [7:0] rd_reg, rd_next;
   logic wrCtrl1;

   assign wrCtrl1 = regWrite && (regAddr == ADDR_CTRL1);

   // register writes and one-cycle-late read data
   always_comb begin
      hgo_next = hgo_reg;
      range_next = range_reg;
      refSel_next = refSel_reg;
      modeReq_next = modeReq_reg;
      mult_next = mult_reg;
      div_next = div_reg;
      firstWr_next = firstWr_reg;
      refLock_next = refLock_reg;
      rd_next = 8'h00;
      if (wrCtrl1) begin
         firstWr_next = 1'b1;
         range_next = regWrData[CTRL1_RANGE_BIT];
         modeReq_next = regWrData[CTRL1_MODE_HI:CTRL1_MODE_LO]; // R1
         if (!firstWr_reg) begin
            hgo_next = regWrData[CTRL1_HGO_BIT]; // R18
            // crystal must be asked for on the very first write
            if (!(regWrData[CTRL1_REFSEL_BIT] &&
                  regWrData[CTRL1_MODE_HI])) begin
               refLock_next = 1'b1; // R5
            end
         end
         refSel_next = regWrData[CTRL1_REFSEL_BIT] & ~refLock_next; // R5
      end
      if (regWrite && (regAddr == ADDR_CTRL2)) begin
         mult_next = regWrData[CTRL2_MULT_HI:CTRL2_MULT_LO];
         div_next = regWrData[CTRL2_DIV_HI:CTRL2_DIV_LO];
      end
      if (regRead) begin
         case (regAddr)
            ADDR_CTRL1: begin
               rd_next[CTRL1_HGO_BIT] = hgo_reg;
               rd_next[CTRL1_RANGE_BIT] = range_reg;
               rd_next[CTRL1_REFSEL_BIT] = refSel_reg;
               rd_next[CTRL1_MODE_HI:CTRL1_MODE_LO] = modeReq_reg;
            end
            ADDR_CTRL2: begin
               rd_next[CTRL2_MULT_HI:CTRL2_MULT_LO] = mult_reg;
               rd_next[CTRL2_DIV_HI:CTRL2_DIV_LO] = div_reg;
            end
            ADDR_STATUS: begin
               rd_next[STAT_MODE_LO+1:STAT_MODE_LO] = modeActual; // R1
               rd_next[STAT_EXT_STABLE_BIT] = extRefStableFlag;
               rd_next[STAT_DCO_STABLE_BIT] = digOscStableFlag;
               rd_next[STAT_SETTLED_BIT] = fllSettledFlag;
               rd_next[STAT_REF_LOCK_BIT] = refLock_reg;
            end
            default: rd_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         hgo_reg <= CTRL1_RESET[CTRL1_HGO_BIT];
         range_reg <= CTRL1_RESET[CTRL1_RANGE_BIT];
         refSel_reg <= CTRL1_RESET[CTRL1_REFSEL_BIT];
         modeReq_reg <= CTRL1_RESET[CTRL1_MODE_HI:CTRL1_MODE_LO];
         mult_reg <= CTRL2_RESET[CTRL2_MULT_HI:CTRL2_MULT_LO];
         div_reg <= CTRL2_RESET[CTRL2_DIV_HI:CTRL2_DIV_LO];
         firstWr_reg <= 1'b0;
         refLock_reg <= 1'b0;
         rd_reg <= 8'h00;
      end else begin
         hgo_reg <= hgo_next;
         range_reg <= range_next;
         refSel_reg <= refSel_next;
         modeReq_reg <= modeReq_next;
         mult_reg <= mult_next;
         div_reg <= div_next;
         firstWr_reg <= firstWr_next;
         refLock_reg <= refLock_next;
         rd_reg <= rd_next;
      end
   end

   assign regRdData = rd_reg;
   assign oscAmpEnable = refSel_reg; // R5
   assign highGainOsc = hgo_reg & refSel_reg; // R17

   // settings staged before the generator acts on them
   logic [8:0] stage1_reg, stage2_reg, prev_reg;
   logic [1:0] req;
   logic [2:0] mult, div;
   logic rangeS, multChanged, reqChanged;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         stage1_reg <= 9'h000;
         stage2_reg <= 9'h000;
         prev_reg <= 9'h000;
      end else begin
         stage1_reg <= {range_reg, modeReq_reg, mult_reg, div_reg}; // R21
         stage2_reg <= stage1_reg; // R4
         prev_reg <= stage2_reg;
      end
   end

   assign {rangeS, req, mult, div} = stage2_reg;
   assign multChanged = stage2_reg[5:3] != prev_reg[5:3];
   assign reqChanged = stage2_reg[7:6] != prev_reg[7:6];

   // multiply and divide decode
   logic [4:0] nVal;
   logic [8:0] rVal;
   assign nVal = 5'd4 + {1'b0, mult, 1'b0}; // R12
   assign rVal = 9'h001 << div; // R13

   // actual mode follows request under the stability conditions
   cms_mode_t mode_reg, mode_next;
   logic ext_ref_stable_flag_reg, ext_ref_stable_flag_next;
   logic dig_osc_stable_flag_reg, dig_osc_stable_flag_next;

   always_comb begin
      case (cms_mode_t'(req)) // R3
         MODE_SELF_CLOCKED: mode_next = MODE_SELF_CLOCKED;
         MODE_ENGAGED_INT:
            mode_next = dig_osc_stable_flag_reg ? MODE_ENGAGED_INT : MODE_SELF_CLOCKED; // R2
         MODE_BYPASSED_EXT:
            mode_next = ext_ref_stable_flag_reg ? MODE_BYPASSED_EXT : MODE_SELF_CLOCKED; // R2
         MODE_ENGAGED_EXT: begin
            if (!dig_osc_stable_flag_reg) begin
               mode_next = MODE_SELF_CLOCKED; // R2
            end else if (!ext_ref_stable_flag_reg) begin
               mode_next = MODE_ENGAGED_INT; // R2
            end else begin
               mode_next = MODE_ENGAGED_EXT; // R2
            end
         end
         default: mode_next = MODE_SELF_CLOCKED;
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_reg <= MODE_SELF_CLOCKED;
      end else begin
         mode_reg <= mode_next;
      end
   end

   assign modeActual = mode_reg;

   // external reference monitor over a fixed window of core cycles
   logic [15:0] monCnt_reg, monCnt_next;
   logic [15:0] extEdges_reg, extEdges_next;
   logic monEnd;
   assign monEnd = monCnt_reg == 16'(MON_WINDOW - 1);

   always_comb begin
      monCnt_next = monEnd ? 16'h0000 : monCnt_reg + 16'h0001;
      extEdges_next = extEdges_reg;
      ext_ref_stable_flag_next = ext_ref_stable_flag_reg;
      if (monEnd) begin
         extEdges_next = 16'h0000;
      end else if (extTick && extEdges_reg != 16'hFFFF) begin
         extEdges_next = extEdges_reg + 16'h0001;
      end
      if (!req[1]) begin
         ext_ref_stable_flag_next = 1'b0; // not monitored, forced low
      end else if (req == MODE_BYPASSED_EXT && !refSel_reg) begin
         ext_ref_stable_flag_next = 1'b1; // external clock without oscillator
      end else if (monEnd) begin
         ext_ref_stable_flag_next = extEdges_reg >= 16'(EXT_MIN_EDGES); // R19
      end
   end

   // comparison cycle: count oscillator ticks over reference periods
   logic [7:0] refCnt_reg, refCnt_next;
   logic [15:0] dcoCnt_reg, dcoCnt_next;
   logic [7:0] goodCnt_reg, goodCnt_next;
   logic settled_reg, settled_next;
   logic initDone_reg, initDone_next;
   logic refTick, cmpEnd, inWindow;
   logic [7:0] cycleLen;
   logic [15:0] target, diff;
   logic engaged, ext;

   assign ext = mode_reg == MODE_ENGAGED_EXT;
   assign engaged = ext || mode_reg == MODE_ENGAGED_INT;
   assign refTick = ext ? extTick : intTick; // R6 R7
   assign cycleLen = ext ? (rangeS ? EXT_CYCLE_LONG : EXT_CYCLE_SHORT)
                         : INT_CYCLE_PERIODS; // R6 R7
   assign cmpEnd = refTick && (refCnt_reg + 8'h01 >= cycleLen);
   // expected count: 128N external, 512N/7 internal
   assign target = ext ? {4'h0, nVal, 7'h00}
                       : {2'h0, nVal, 9'h000} / INT_REF_DIV; // R10 R11
   assign diff = (dcoCnt_reg > target) ? dcoCnt_reg - target
                                       : target - dcoCnt_reg;
   assign inWindow = diff <= 16'(LOCK_TOL);

   always_comb begin
      refCnt_next = refCnt_reg;
      dcoCnt_next = dcoCnt_reg;
      goodCnt_next = goodCnt_reg;
      settled_next = settled_reg;
      initDone_next = initDone_reg;
      dig_osc_stable_flag_next = dig_osc_stable_flag_reg;
      if (dcoTick && dcoCnt_reg != 16'hFFFF) begin
         dcoCnt_next = dcoCnt_reg + 16'h0001;
      end
      if (refTick) begin
         refCnt_next = refCnt_reg + 8'h01;
      end
      if (cmpEnd) begin
         refCnt_next = 8'h00;
         dcoCnt_next = {15'h0000, dcoTick};
         dig_osc_stable_flag_next = dcoCnt_reg >= 16'(DCO_MIN_COUNT); // R6
         if (engaged && inWindow) begin
            if (goodCnt_reg + 8'h01 >= 8'(LOCK_SAMPLES)) begin
               settled_next = 1'b1;
            end else begin
               goodCnt_next = goodCnt_reg + 8'h01;
            end
         end else begin
            goodCnt_next = 8'h00;
            settled_next = 1'b0; // unexpected loss
         end
      end
      if (settled_next && ext) begin
         initDone_next = 1'b1;
      end
      // expected loss of lock restarts the comparisons
      if (multChanged || reqChanged || mode_next != mode_reg) begin
         refCnt_next = 8'h00;
         dcoCnt_next = 16'h0000;
         goodCnt_next = 8'h00;
         settled_next = 1'b0; // R20
      end
      // unengaged modes still compare, for the oscillator flag only
      if (!engaged) begin
         goodCnt_next = 8'h00;
         settled_next = 1'b0; // R6
      end
      if (multChanged || !ext) begin
         initDone_next = 1'b0; // R8
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         monCnt_reg <= 16'h0000;
         extEdges_reg <= 16'h0000;
         ext_ref_stable_flag_reg <= 1'b0;
         refCnt_reg <= 8'h00;
         dcoCnt_reg <= 16'h0000;
         goodCnt_reg <= 8'h00;
         settled_reg <= 1'b0;
         initDone_reg <= 1'b0;
         dig_osc_stable_flag_reg <= 1'b0;
      end else begin
         monCnt_reg <= monCnt_next;
         extEdges_reg <= extEdges_next;
         ext_ref_stable_flag_reg <= ext_ref_stable_flag_next;
         refCnt_reg <= refCnt_next;
         dcoCnt_reg <= dcoCnt_next;
         goodCnt_reg <= goodCnt_next;
         settled_reg <= settled_next;
         initDone_reg <= initDone_next;
         dig_osc_stable_flag_reg <= dig_osc_stable_flag_next;
      end
   end

   assign extRefStableFlag = ext_ref_stable_flag_reg;
   assign digOscStableFlag = dig_osc_stable_flag_reg;
   assign fllSettledFlag = settled_reg;

   // output clock source and divisor
   cms_src_t outSrc, fixSrc;
   logic [8:0] outDiv, fixDiv;
   logic [10:0] pn;
   logic [10:0] fourR;
   logic ratioOk;

   assign pn = rangeS ? {6'h00, nVal}
                      : {nVal, 6'h00}; // R11 P of 1 or 64
   assign fourR = {rVal, 2'b00} >> (2 - FIXED_MIN_RATIO_SHIFT);
   assign ratioOk = pn >= fourR;

   always_comb begin
      outSrc = (mode_reg == MODE_BYPASSED_EXT) ? SRC_EXT : SRC_DCO; // R9
      outDiv = (ext && !initDone_reg) ? {rVal[7:0], 1'b0} : rVal; // R8
      if (mode_reg == MODE_ENGAGED_EXT && ratioOk && settled_reg) begin
         fixSrc = SRC_EXT; // R14
         fixDiv = FIXED_DIV; // R14
      end else if (!mode_reg[1]) begin
         fixSrc = SRC_NONE; // R15
         fixDiv = 9'h001;
      end else begin
         fixSrc = SRC_BUS; // R14
         fixDiv = 9'h001;
      end
   end

   // main output clock, oscillator or external ticks over R, or over 2R in engaged-ext before lock
   cms_tick_divider #(.W(9)) outDivider (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .tickDco(dcoTick),
      .tickExt(extTick),
      .tickBus(1'b0),
      .srcSel(outSrc),
      .divisor(outDiv),
      .pulseOut(clockGenOutput)
   );

   // fixed frequency clock for peripherals
   cms_tick_divider #(.W(9)) fixDivider (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .tickDco(1'b0),
      .tickExt(extTick),
      .tickBus(busClockInternal),
      .srcSel(fixSrc),
      .divisor(fixDiv),
      .pulseOut(fixedFreqClock)
   );
endmodule
`default_nettype wire

// ===== rtl/cms_pkg.sv
// constants and types shared by the clock mode select block
`default_nettype none
package cms_pkg;
   // register offsets on the plain register port
   localparam logic [1:0] ADDR_CTRL1 = 2'h0;
   localparam logic [1:0] ADDR_CTRL2 = 2'h1;
   localparam logic [1:0] ADDR_STATUS = 2'h2;
   // field positions in the control registers
   localparam int CTRL1_HGO_BIT = 7;
   localparam int CTRL1_RANGE_BIT = 6;
   localparam int CTRL1_REFSEL_BIT = 5;
   localparam int CTRL1_MODE_HI = 4;
   localparam int CTRL1_MODE_LO = 3;
   localparam int CTRL2_MULT_HI = 6;
   localparam int CTRL2_MULT_LO = 4;
   localparam int CTRL2_DIV_HI = 2;
   localparam int CTRL2_DIV_LO = 0;
   // field positions in the status register
   localparam int STAT_MODE_LO = 0;
   localparam int STAT_EXT_STABLE_BIT = 2;
   localparam int STAT_DCO_STABLE_BIT = 3;
   localparam int STAT_SETTLED_BIT = 4;
   localparam int STAT_REF_LOCK_BIT = 5;
   // values after reset
   localparam logic [7:0] CTRL1_RESET = 8'h00;
   localparam logic [7:0] CTRL2_RESET = 8'h00;
   // comparison cycle lengths in reference periods
   localparam logic [7:0] INT_CYCLE_PERIODS = 8'h08;
   localparam logic [7:0] EXT_CYCLE_SHORT = 8'h02;
   localparam logic [7:0] EXT_CYCLE_LONG = 8'h80;
   // internal reference predivide and prescale shifts (64 = 1 << 6)
   localparam logic [15:0] INT_REF_DIV = 16'h0007;
   localparam int PRESCALE_LOW_SHIFT = 6;
   // fixed clock divide and least ratio for it
   localparam logic [8:0] FIXED_DIV = 9'h002;
   localparam int FIXED_MIN_RATIO_SHIFT = 2;
   // clock modes, same code for request and actual
   typedef enum logic [1:0] {
      MODE_SELF_CLOCKED = 2'b00,
      MODE_ENGAGED_INT = 2'b01,
      MODE_BYPASSED_EXT = 2'b10,
      MODE_ENGAGED_EXT = 2'b11
   } cms_mode_t;
   // tick source of a divider
   typedef enum logic [1:0] {
      SRC_NONE = 2'b00,
      SRC_DCO = 2'b01,
      SRC_EXT = 2'b10,
      SRC_BUS = 2'b11
   } cms_src_t;
endpackage
`default_nettype wire

// ===== rtl/cms_tick_divider.sv
// glitch-free tick divider, source and divisor change only at wrap or while stopped, except a stop, which takes effect at once
`default_nettype none
module cms_tick_divider #(
   parameter int W = 9
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic tickDco,
   input wire logic tickExt,
   input wire logic tickBus,
   input wire cms_pkg::cms_src_t srcSel,
   input wire logic [W-1:0] divisor,
   output logic pulseOut
);
   import cms_pkg::*;

   cms_src_t curSrc_reg, curSrc_next;
   logic [W-1:0] curDiv_reg, curDiv_next;
   logic [W-1:0] cnt_reg, cnt_next;
   logic pulse_reg, pulse_next;
   logic tick;
   cms_src_t src;
   logic [W-1:0] dv;

   // count source ticks, take new settings only at the end of a period or while stopped
   always_comb begin
      src = (curSrc_reg == SRC_NONE) ? srcSel : curSrc_reg;
      dv = (curSrc_reg == SRC_NONE) ? divisor : curDiv_reg;
      curSrc_next = src;
      curDiv_next = dv;
      cnt_next = cnt_reg;
      pulse_next = 1'b0;
      case (src)
         SRC_DCO: tick = tickDco;
         SRC_EXT: tick = tickExt;
         SRC_BUS: tick = tickBus;
         default: tick = 1'b0;
      endcase
      if (tick) begin
         if (cnt_reg + 1'b1 >= dv) begin
            pulse_next = 1'b1;
            cnt_next = '0;
            curSrc_next = srcSel; // R21
            curDiv_next = divisor; // R21
         end else begin
            cnt_next = cnt_reg + 1'b1;
         end
      end
      // a stop halts at once, no late pulse
      if (srcSel == SRC_NONE) begin
         curSrc_next = SRC_NONE;
         cnt_next = '0;
         pulse_next = 1'b0; // R15
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         curSrc_reg <= SRC_NONE;
         curDiv_reg <= '0;
         cnt_reg <= '0;
         pulse_reg <= 1'b0;
      end else begin
         curSrc_reg <= curSrc_next;
         curDiv_reg <= curDiv_next;
         cnt_reg <= cnt_next;
         pulse_reg <= pulse_next;
      end
   end

   assign pulseOut = pulse_reg;
endmodule
`default_nettype wire

// ===== testbench/cms_clock_mode_chk.sv
// port assertions for the clock mode select block
`default_nettype none
module cms_clock_mode_chk (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [1:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regRdData,
   input wire logic clockGenOutput,
   input wire logic fixedFreqClock,
   input wire logic oscAmpEnable,
   input wire logic highGainOsc,
   input wire cms_pkg::cms_mode_t modeActual,
   input wire logic extRefStableFlag,
   input wire logic digOscStableFlag,
   input wire logic fllSettledFlag,
   input wire logic busClockInternal
);
   timeunit 1ns;
   timeprecision 1ns;
   import cms_pkg::*;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);
   // bus steps and mode groups
   sequence s_stat_rd; regRead && regAddr == ADDR_STATUS; endsequence
   sequence s_c1_wr; regWrite && regAddr == ADDR_CTRL1; endsequence
   sequence s_fix_off;
      modeActual == MODE_SELF_CLOCKED || modeActual == MODE_ENGAGED_INT;
   endsequence
   // read port, mode choice, fixed clock and oscillator relations
   property p_rd_idle; !regRead |=> regRdData == 8'h00; endproperty
   property p_rd_mode;
      s_stat_rd |=> regRdData[1:0] == $past(modeActual);
   endproperty
   property p_mode_osc;
      $changed(modeActual) && modeActual[0]
         |-> digOscStableFlag || $past(digOscStableFlag);
   endproperty
   property p_mode_ext;
      $changed(modeActual) && modeActual[1]
         |-> extRefStableFlag || $past(extRefStableFlag);
   endproperty
   property p_no_jump; s_c1_wr |=> $stable(modeActual); endproperty
   property p_fix_off; s_fix_off [*2] |-> !fixedFreqClock; endproperty
   property p_fix_bus;
      modeActual == MODE_BYPASSED_EXT
         |=> fixedFreqClock == $past(busClockInternal);
   endproperty
   property p_hgo_ref;
      highGainOsc |=> highGainOsc || !oscAmpEnable;
   endproperty
   property p_amp_off;
      s_c1_wr ##0 !regWrData[CTRL1_REFSEL_BIT] |-> ##2 !oscAmpEnable;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data not idle");
   a_rd_mode: assert property (p_rd_mode)
      else $error("status mode field wrong");
   a_mode_osc: assert property (p_mode_osc)
      else $error("engaged mode without stable oscillator");
   a_mode_ext: assert property (p_mode_ext)
      else $error("external mode without stable reference");
   a_no_jump: assert property (p_no_jump)
      else $error("mode moved right after request write");
   a_fix_off: assert property (p_fix_off)
      else $error("fixed clock running while off");
   a_fix_bus: assert property (p_fix_bus)
      else $error("fixed clock not following bus clock");
   a_hgo_ref: assert property (p_hgo_ref)
      else $error("high gain dropped while external on");
   a_amp_off: assert property (p_amp_off)
      else $error("amplifier on without external select");
endmodule
bind cms_clock_mode cms_clock_mode_chk u_chk (
   .core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr),
   .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
   .regRdData(regRdData), .clockGenOutput(clockGenOutput),
   .fixedFreqClock(fixedFreqClock), .oscAmpEnable(oscAmpEnable),
   .highGainOsc(highGainOsc), .modeActual(modeActual),
   .extRefStableFlag(extRefStableFlag),
   .digOscStableFlag(digOscStableFlag), .fllSettledFlag(fllSettledFlag),
   .busClockInternal(busClockInternal)
);
`default_nettype wire

// ===== testbench/cms_clock_mode_bench.sv
// self-checking bench for the clock mode select block
`default_nettype none
module cms_clock_mode_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import cms_pkg::*;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [1:0] regAddr = 2'h0;
   logic [7:0] regWrData = 8'h00;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic extRefClock = 1'b0, digOscClock = 1'b0, intRefClock = 1'b0;
   logic busClockInternal = 1'b0;
   logic extOn = 1'b1;
   logic [7:0] cyc = 8'h00;
   logic [2:0] extCnt = 3'h0;
   logic [7:0] regRdData;
   logic clockGenOutput, fixedFreqClock, oscAmpEnable, highGainOsc;
   logic extRefStableFlag, digOscStableFlag, fllSettledFlag;
   cms_mode_t modeActual;
   int badCount = 0;
   int samplesChecked = 0;
   // core clock
   initial begin
      forever #25 core_clk = ~core_clk;
   end
   // pin clocks: oscillator 4, internal 8, external 6 core cycles
   always @(posedge core_clk) begin
      cyc <= cyc + 8'h01;
      digOscClock <= cyc[1];
      intRefClock <= cyc[2];
      busClockInternal <= (cyc[1:0] == 2'h0);
      extCnt <= (extCnt == 3'h5) ? 3'h0 : extCnt + 3'h1;
      extRefClock <= extOn && (extCnt < 3'h3);
   end
   cms_clock_mode #(.MON_WINDOW(32), .LOCK_SAMPLES(2)) u_dut (
      .core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData), .extRefClock(extRefClock),
      .digOscClock(digOscClock), .intRefClock(intRefClock),
      .busClockInternal(busClockInternal),
      .clockGenOutput(clockGenOutput), .fixedFreqClock(fixedFreqClock),
      .oscAmpEnable(oscAmpEnable), .highGainOsc(highGainOsc),
      .modeActual(modeActual), .extRefStableFlag(extRefStableFlag),
      .digOscStableFlag(digOscStableFlag),
      .fllSettledFlag(fllSettledFlag)
   );
   // compare and count
   task automatic chk(input logic [15:0] got, exp, input string what);
      samplesChecked++;
      if (got !== exp) begin
         badCount++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // one-cycle register write
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge core_clk);
      regWrite <= 1'b0;
   endtask
   // one-cycle read, data looked at in the following cycle
   task automatic rd(input logic [1:0] a, input logic [7:0] m, e,
                     input string what);
      @(posedge core_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge core_clk);
      regRead <= 1'b0;
      @(negedge core_clk);
      chk(16'(regRdData & m), 16'(e), what);
   endtask
   // bounded wait for the actual mode
   task automatic wait_mode(input cms_mode_t m, input string what);
      int n;
      n = 0;
      while (modeActual !== m && n < 400) begin
         @(negedge core_clk);
         n++;
      end
      chk(16'(modeActual), 16'(m), what);
   endtask
   // output pulse spacing, taken after the divisor has switched
   task automatic out_period(input int exp, input string what);
      int n;
      for (int k = 0; k < 4; k++) begin
         n = 0;
         do begin
            @(negedge core_clk);
            n++;
         end while (clockGenOutput !== 1'b1 && n < 3000);
      end
      chk(16'(n), 16'(exp), what);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samplesChecked, badCount);
      if (badCount == 0 && samplesChecked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // watchdog against a hang
   initial begin
      repeat (40000) @(posedge core_clk);
      badCount++;
      finish_test;
   end
   // test sequence
   initial begin
      int n;
      repeat (8) @(posedge core_clk);
      reset_n <= 1'b1;
      @(negedge core_clk);
      chk(16'(modeActual), 16'h0000, "reset mode");
      wr(2'h3, 8'hFF);
      rd(ADDR_CTRL1, 8'hFF, CTRL1_RESET, "ctrl1 reset");
      rd(ADDR_CTRL2, 8'hFF, CTRL2_RESET, "ctrl2 reset");
      rd(2'h3, 8'hFF, 8'h00, "hole read");
      $display("test reset done");
      // crystal on first write, high gain taken once
      wr(ADDR_CTRL1, 8'hB0);
      wait_mode(MODE_BYPASSED_EXT, "bypassed");
      wr(ADDR_CTRL1, 8'h30);
      rd(ADDR_CTRL1, 8'hF8, 8'hB0, "gain kept");
      chk(16'({highGainOsc, oscAmpEnable}), 16'h0003, "amp on");
      for (int c = 0; c < 8; c++) begin
         wr(ADDR_CTRL2, 8'(8'h30 | c));
         rd(ADDR_CTRL2, 8'h77, 8'(8'h30 | c), "ctrl2 back");
         out_period(6 << c, "bypassed divide");
      end
      $display("test bypassed done");
      // self clocked, then engaged internal
      wr(ADDR_CTRL2, 8'h31);
      wr(ADDR_CTRL1, 8'h20);
      wait_mode(MODE_SELF_CLOCKED, "self");
      out_period(8, "self divide");
      wr(ADDR_CTRL1, 8'h28);
      wait_mode(MODE_ENGAGED_INT, "engaged int");
      n = 0;
      repeat (12) begin
         @(negedge core_clk);
         if (fixedFreqClock !== 1'b0) n++;
      end
      chk(16'(n), 16'h0000, "fixed off");
      $display("test internal done");
      // engaged external while unlocked divides by 2R
      wr(ADDR_CTRL2, 8'h30);
      wr(ADDR_CTRL1, 8'h38);
      wait_mode(MODE_ENGAGED_EXT, "engaged ext");
      out_period(8, "unlocked divide");
      chk(16'(fllSettledFlag), 16'h0000, "not settled");
      n = 0;
      while (fixedFreqClock !== 1'b1 && n < 20) begin
         @(negedge core_clk);
         n++;
      end
      chk(16'(fixedFreqClock), 16'h0001, "fixed on bus");
      @(posedge core_clk);
      extOn <= 1'b0;
      wait_mode(MODE_ENGAGED_INT, "reference lost");
      rd(ADDR_STATUS, 8'h0F, 8'h09, "status lost");
      $display("test external done");
      // second reset, first write without crystal locks the select
      @(posedge core_clk);
      reset_n <= 1'b0;
      repeat (8) @(posedge core_clk);
      reset_n <= 1'b1;
      @(negedge core_clk);
      chk(16'(modeActual), 16'h0000, "reset mode again");
      wr(ADDR_CTRL1, 8'h08);
      wr(ADDR_CTRL1, 8'hB0);
      rd(ADDR_STATUS, 8'h20, 8'h20, "select locked");
      rd(ADDR_CTRL1, 8'hE0, 8'h00, "ctrl1 locked");
      chk(16'({highGainOsc, oscAmpEnable}), 16'h0000, "amp off");
      $display("test lock done");
      finish_test;
   end
endmodule
`default_nettype wire
